// ===== dv/set_reset_latch_unit_tb_top.sv
// Purpose: self-checking bench for the latch unit
// Assumes: one clock; far model drives comparator and pin
// Notes:   q_exp tracks the latch from writes and stimulus
`timescale 1ns/10ps
module set_reset_latch_unit_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [1:0]  avs_address = 2'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        cmp_drive = 1'b0;
    logic        pin_drive = 1'b0;
    logic        cmp_res;
    logic        ext_in;
    logic        t_pin, t_oe_b, c_pin, c_oe_b;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          t1;
    logic [1:0]  q_exp;
    logic [7:0]  pri = 8'h00;
    logic [7:0]  d;
    logic [31:0] rdv;
    int          bits[4] = '{7, 4, 3, 0};

    srl_latch_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .external_latch_input(ext_in),
        .comparator_result(cmp_res), .true_output_pin(t_pin), .true_output_oe_b(t_oe_b),
        .complement_output_pin(c_pin), .complement_output_oe_b(c_oe_b));
    srl_far_model u_far (.clk_sys(clk_sys), .cmp_drive(cmp_drive), .pin_drive(pin_drive),
        .comparator_result(cmp_res), .external_latch_input(ext_in));

    // free clock, 10 ns
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    // hang guard, well above the few thousand cycles needed
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            $display("Error at %0t: timeout", $time);
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one avalon cycle; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] dd,
                       input logic [3:0] be);
        @(posedge clk_sys);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= {24'h0, dd};
        avs_byteenable <= be;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        rdv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // model: reset pulse wins over set pulse
        if (w && be[0] && a == 2'h0)
        begin
            pri = dd;
            if (dd[0])
                q_exp = 2'h0;
            else if (dd[1])
                q_exp = 2'h1;
        end
    endtask : bus

    task automatic wr(input logic [1:0] a, input logic [7:0] dd);
        bus(1'b1, a, dd, 4'h1);
    endtask : wr

    // compare all four pin outputs against the model
    task automatic pins();
        logic t;
        logic c;
        t = pri[7] && pri[3];
        c = pri[7] && pri[2];
        @(negedge clk_sys);
        chk(t_oe_b, !t);
        chk(c_oe_b, !c);
        chk(t_pin, t ? q_exp[0] : 1'b0);
        chk(c_pin, c ? !q_exp[0] : 1'b0);
    endtask : pins

    // drop the watched pin via a one-cycle comparator pulse, then wait for its next rise
    task automatic edge_t(input int m);
        @(posedge clk_sys);
        cmp_drive <= 1'b1;
        @(posedge clk_sys);
        cmp_drive <= 1'b0;
        @(negedge clk_sys);
        while ((m ? c_pin : t_pin) !== 1'b1)
            @(negedge clk_sys);
    endtask : edge_t

    initial
    begin
        void'($urandom(41));
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        bus(1'b0, 2'h0, 8'h00, 4'h1);
        chk(rdv, 32'h0);
        bus(1'b0, 2'h1, 8'h00, 4'h1);
        chk(rdv, 32'h0);
        // latch defined before any output is enabled
        wr(2'h0, 8'h01);
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            d = $urandom;
            wr(2'h0, d);
            pins();
            bus(1'b0, 2'h0, 8'h00, 4'h1);
            chk(rdv, {24'h0, pri & 8'hfc});
            d = $urandom & 8'h99;
            wr(2'h1, d);
            bus(1'b0, 2'h1, 8'h00, 4'h1);
            chk(rdv, {24'h0, d & 8'hdd});
            bus(1'b0, 2'h2, 8'h00, 4'h1);
            chk(rdv[2:0], {2'h0, q_exp[0]});
        end
        bus(1'b1, 2'h0, ~pri, 4'h0);
        bus(1'b1, 2'h3, 8'hff, 4'h1);
        bus(1'b0, 2'h3, 8'h00, 4'h1);
        chk(rdv, 32'h0);
        bus(1'b0, 2'h0, 8'h00, 4'h1);
        chk(rdv, {24'h0, pri & 8'hfc});
        $display("test registers done");
        wr(2'h1, 8'h00);
        // set, no-op, reset, then both pulses together
        foreach (bits[i])
        begin
            d = (i == 0) ? 8'h8e : (i == 1) ? 8'h8c : (i == 2) ? 8'h8d : 8'h8f;
            wr(2'h0, d);
            pins();
        end
        $display("test soft pulses done");
        foreach (bits[i])
        begin
            for (int e = 1; e >= 0; e--)
            begin
                wr(2'h0, (bits[i] >= 4) ? 8'h8d : 8'h8e);
                wr(2'h1, e ? (8'h01 << bits[i]) : 8'h00);
                if (bits[i] == 7 || bits[i] == 3)
                    pin_drive <= 1'b1;
                else
                    cmp_drive <= 1'b1;
                repeat (6) @(posedge clk_sys);
                if (e)
                    q_exp = (bits[i] >= 4) ? 2'h1 : 2'h0;
                pins();
                chk(t_pin, q_exp[0]);
                @(posedge clk_sys);
                pin_drive <= 1'b0;
                cmp_drive <= 1'b0;
                repeat (6) @(posedge clk_sys);
            end
        end
        $display("test sources done");
        for (int m = 0; m < 2; m++)
        begin
            for (int c = 0; c < 8; c++)
            begin
                wr(2'h1, m ? 8'h14 : 8'h41);
                wr(2'h0, 8'h8c | (c << 4));
                edge_t(m);
                t1 = cyc;
                edge_t(m);
                chk(cyc - t1, 4 << c);
            end
        end
        $display("test divider done");
        wr(2'h1, 8'h00);
        wr(2'h0, 8'h0d);
        pins();
        $display("test disable done");
        finish_test();
    end
endmodule : set_reset_latch_unit_tb_top

// ===== dv/srl_far_model.sv
// Purpose: far side of the latch: comparator and external pin
// Assumes: bench commands the levels
// Notes:   comparator level retimed to clk_sys like the upstream synchroniser
`timescale 1ns/10ps
module srl_far_model (
    input  wire logic clk_sys,
    input  wire logic cmp_drive,
    input  wire logic pin_drive,
    output logic      comparator_result = 1'b0,
    output logic      external_latch_input
);
    // only the synchronised comparator form ever reaches the latch
    always @(posedge clk_sys)
    begin
        comparator_result <= cmp_drive;
    end
    // pin is asynchronous by nature, passed straight on
    assign external_latch_input = pin_drive;
endmodule : srl_far_model

// ===== dv/srl_latch_sva.sv
// Purpose: port checks of the latch unit
// Assumes: bound to srl_latch_top
// Notes:   control registers shadowed from accepted writes
`timescale 1ns/10ps
module srl_latch_sva (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic [1:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        external_latch_input,
    input wire logic        comparator_result,
    input wire logic        true_output_pin,
    input wire logic        true_output_oe_b,
    input wire logic        complement_output_pin,
    input wire logic        complement_output_oe_b
);
    logic [7:0] pri_sh;
    logic [7:0] src_sh;
    // accept strobes and derived enables
    wire        wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire        rd_ok = avs_read && !avs_waitrequest;
    wire        t_en = pri_sh[7] && pri_sh[3];
    wire        c_en = pri_sh[7] && pri_sh[2];
    wire        both_on = t_en && c_en;
    wire        req = avs_read || avs_write;
    // shadows move on the accept edge, like the registers themselves
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pri_sh <= 8'h00;
            src_sh <= 8'h00;
        end
        else if (wr_ok && avs_address == 2'h0)
            pri_sh <= avs_writedata[7:0];
        else if (wr_ok && avs_address == 2'h1)
            src_sh <= avs_writedata[7:0];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_true_oe_gate: assert property (true_output_oe_b == !t_en)
        else $error("true output enable wrong");
    a_comp_oe_gate: assert property (complement_output_oe_b == !c_en)
        else $error("complement output enable wrong");
    a_pins_idle_low: assert property (!(true_output_oe_b && true_output_pin)
        && !(complement_output_oe_b && complement_output_pin))
        else $error("disabled pin not low");
    a_dual_inverse: assert property (both_on |-> complement_output_pin != true_output_pin)
        else $error("outputs not complementary");
    a_one_wait: assert property ($rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("wait state count wrong");
    a_wait_idle: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest without request");
    a_pulse_rd_zero: assert property (rd_ok && avs_address == 2'h0 |-> avs_readdata[1:0] == 2'h0)
        else $error("pulse bits read nonzero");
    a_rsvd_rd_zero: assert property (rd_ok && avs_address == 2'h1
        |-> !avs_readdata[5] && !avs_readdata[1])
        else $error("reserved bits read nonzero");
    a_unmapped_zero: assert property (rd_ok && avs_address == 2'h3 |-> avs_readdata == 32'h0)
        else $error("unmapped read nonzero");
    a_cmp_reset_wins: assert property ((src_sh[0] && comparator_result && t_en)[*2]
        |-> !true_output_pin)
        else $error("comparator reset ignored");

    // main scenarios reached
    c_write: cover property (wr_ok);
    c_status: cover property (rd_ok && avs_address == 2'h2);
    c_both: cover property (both_on && true_output_pin);
endmodule : srl_latch_sva

bind srl_latch_top srl_latch_sva u_sva (
    .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_latch_input(external_latch_input), .comparator_result(comparator_result),
    .true_output_pin(true_output_pin), .true_output_oe_b(true_output_oe_b),
    .complement_output_pin(complement_output_pin),
    .complement_output_oe_b(complement_output_oe_b));

// ===== hw/srl_latch_top.sv
// Purpose: set/reset latch with selectable sources and gated pin outputs
// Assumes: avalon-mm slave on clk_sys; comparator input already synchronised
// Notes:   the latch itself is level sensitive and holds no reset
`timescale 1ns/10ps
`include "srl_regs.svh"

module srl_latch_top (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [1:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        external_latch_input,
    input  wire logic        comparator_result,
    output logic             true_output_pin,
    output logic             true_output_oe_b,
    output logic             complement_output_pin,
    output logic             complement_output_oe_b
);

    // reset release synchroniser
    logic rst_meta_b;
    logic rst_sync_b;

    // external pin synchroniser and filtered level
    logic pin_sync1_reg;
    logic pin_sync2_reg;
    logic pin_sync3_reg;
    logic pin_level_reg;
    logic pin_level_next;

    // bus slave state
    srl_pkg::srl_bus_state_t bus_state_reg;
    srl_pkg::srl_bus_state_t bus_state_next;
    logic [31:0]             readdata_reg;
    logic [31:0]             readdata_next;

    // register decode
    logic bus_req;
    logic bus_accept;
    logic wr_accept;
    logic wr_low_byte;
    logic sel_primary;
    logic sel_source;
    logic sel_status;
    logic wr_primary;
    logic wr_source;

    // software state
    logic       latch_enable_reg;
    logic [2:0] divided_pulse_select_reg;
    logic       true_output_enable_reg;
    logic       complement_output_enable_reg;
    logic       soft_set_pulse_reg;
    logic       soft_reset_pulse_reg;
    logic       pin_set_enable_reg;
    logic       clock_set_enable_reg;
    logic       comparator_set_enable_reg;
    logic       pin_reset_enable_reg;
    logic       clock_reset_enable_reg;
    logic       comparator_reset_enable_reg;

    // read views
    logic [7:0] primary_view;
    logic [7:0] source_view;
    logic [7:0] status_view;

    // latch sources and state
    logic div_pulse;
    logic latch_set;
    logic latch_reset;
    logic latch_q;
    logic true_drive;
    logic complement_drive;

    // individual latch source terms, all but the soft pulses already gated by an enable
    logic        set_soft;
    logic        set_clock;
    logic        set_pin;
    logic        set_cmp;
    logic        reset_soft;
    logic        reset_clock;
    logic        reset_pin;
    logic        reset_cmp;
    logic        pin_stages_agree;
    logic [31:0] read_word;

    // reset images of the two control registers, sliced per field below
    localparam logic [7:0] PRI_RST = `SRL_PRIMARY_RESET;
    localparam logic [7:0] SRC_RST = `SRL_SOURCE_RESET;

    // reset: asserts at once, releases two edges later
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // three-stage pin capture; only stages two and three are compared
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            pin_sync1_reg <= 1'b0;
            pin_sync2_reg <= 1'b0;
            pin_sync3_reg <= 1'b0;
            pin_level_reg <= 1'b0;
        end
        else
        begin
            pin_sync1_reg <= external_latch_input;
            pin_sync2_reg <= pin_sync1_reg;
            pin_sync3_reg <= pin_sync2_reg;
            pin_level_reg <= pin_level_next;
        end
    end

    // a change counts only once two settled stages agree; stage one may be
    // metastable, so it feeds nothing but stage two
    assign pin_stages_agree = pin_sync2_reg == pin_sync3_reg;
    assign pin_level_next   = pin_stages_agree ? pin_sync3_reg : pin_level_reg;

    // one wait state per access: request seen, then answered
    assign bus_req         = avs_read | avs_write;
    assign bus_accept      = bus_req & (bus_state_reg == srl_pkg::SRL_BUS_ACK);
    assign avs_waitrequest = bus_req & (bus_state_reg != srl_pkg::SRL_BUS_ACK);

    // handshake sequencer: idle notes a request, ack answers it for one cycle;
    // the fixed wait state gives the read mux a full cycle before data stands
    always_comb
    begin
        bus_state_next = srl_pkg::SRL_BUS_IDLE;
        case (bus_state_reg)
            srl_pkg::SRL_BUS_IDLE:
            begin
                if (bus_req)
                    bus_state_next = srl_pkg::SRL_BUS_ACK;
            end
            srl_pkg::SRL_BUS_ACK:
            begin
                bus_state_next = srl_pkg::SRL_BUS_IDLE;
            end
            default:
            begin
                bus_state_next = srl_pkg::SRL_BUS_IDLE;
            end
        endcase
    end

    // address decode; unmapped words read zero and ignore writes
    assign sel_primary = avs_address == `SRL_IDX_PRIMARY;
    assign sel_source  = avs_address == `SRL_IDX_SOURCE;
    assign sel_status  = avs_address == `SRL_IDX_STATUS;
    assign wr_accept   = bus_accept & avs_write;
    assign wr_low_byte = wr_accept & avs_byteenable[0];
    assign wr_primary  = wr_low_byte & sel_primary;
    assign wr_source   = wr_low_byte & sel_source;

    // word chosen by index; unmapped words read zero
    assign read_word     = sel_primary ? {24'h000000, primary_view}
                         : sel_source  ? {24'h000000, source_view}
                         : sel_status  ? {24'h000000, status_view}
                         : 32'h00000000;

    // read data is captured while waitrequest is high, so it stands at accept
    assign readdata_next = avs_read ? read_word : readdata_reg;

    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            bus_state_reg <= srl_pkg::SRL_BUS_IDLE;
            readdata_reg  <= 32'h00000000;
        end
        else
        begin
            bus_state_reg <= bus_state_next;
            if (bus_state_reg == srl_pkg::SRL_BUS_IDLE)
                readdata_reg <= readdata_next;
        end
    end

    assign avs_readdata = readdata_reg;

    // primary control fields
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            latch_enable_reg             <= PRI_RST[`SRL_PRI_LATCH_ENABLE];
            divided_pulse_select_reg     <= PRI_RST[`SRL_PRI_DIV_SEL_HI:`SRL_PRI_DIV_SEL_LO];
            true_output_enable_reg       <= PRI_RST[`SRL_PRI_TRUE_OE];
            complement_output_enable_reg <= PRI_RST[`SRL_PRI_COMP_OE];
        end
        else if (wr_primary)
        begin
            latch_enable_reg             <= avs_writedata[`SRL_PRI_LATCH_ENABLE];
            divided_pulse_select_reg     <=
                avs_writedata[`SRL_PRI_DIV_SEL_HI:`SRL_PRI_DIV_SEL_LO];
            true_output_enable_reg       <= avs_writedata[`SRL_PRI_TRUE_OE];
            complement_output_enable_reg <= avs_writedata[`SRL_PRI_COMP_OE];
        end
    end

    // soft pulses: a written one lives exactly one clock, a zero does nothing
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            soft_set_pulse_reg   <= 1'b0;
            soft_reset_pulse_reg <= 1'b0;
        end
        else
        begin
            soft_set_pulse_reg   <= wr_primary & avs_writedata[`SRL_PRI_SOFT_SET];
            soft_reset_pulse_reg <= wr_primary & avs_writedata[`SRL_PRI_SOFT_RESET];
        end
    end

    // source selection; reserved bits are never stored
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            pin_set_enable_reg          <= SRC_RST[`SRL_SRC_PIN_SET];
            clock_set_enable_reg        <= SRC_RST[`SRL_SRC_CLK_SET];
            comparator_set_enable_reg   <= SRC_RST[`SRL_SRC_CMP_SET];
            pin_reset_enable_reg        <= SRC_RST[`SRL_SRC_PIN_RESET];
            clock_reset_enable_reg      <= SRC_RST[`SRL_SRC_CLK_RESET];
            comparator_reset_enable_reg <= SRC_RST[`SRL_SRC_CMP_RESET];
        end
        else if (wr_source)
        begin
            pin_set_enable_reg          <= avs_writedata[`SRL_SRC_PIN_SET];
            clock_set_enable_reg        <= avs_writedata[`SRL_SRC_CLK_SET];
            comparator_set_enable_reg   <= avs_writedata[`SRL_SRC_CMP_SET];
            pin_reset_enable_reg        <= avs_writedata[`SRL_SRC_PIN_RESET];
            clock_reset_enable_reg      <= avs_writedata[`SRL_SRC_CLK_RESET];
            comparator_reset_enable_reg <= avs_writedata[`SRL_SRC_CMP_RESET];
        end
    end

    // read views: pulse bits and reserved bits always zero
    assign primary_view = {latch_enable_reg,
                           divided_pulse_select_reg,
                           true_output_enable_reg,
                           complement_output_enable_reg,
                           2'b00};
    assign source_view  = {pin_set_enable_reg,
                           clock_set_enable_reg,
                           1'b0,
                           comparator_set_enable_reg,
                           pin_reset_enable_reg,
                           clock_reset_enable_reg,
                           1'b0,
                           comparator_reset_enable_reg};
    // status bit 0 (latch_q) reads unknown until firmware has pulsed the latch after reset
    assign status_view  = {5'b00000,
                           comparator_result,
                           pin_level_reg,
                           latch_q};

    // periodic source
    srl_pulse_div #(
        .SEL_W (`SRL_DIV_SEL_W),
        .CNT_W (`SRL_DIV_CNT_W)
    ) u_pulse_div (
        .clk_sys    (clk_sys),
        .rst_sync_b (rst_sync_b),
        .div_code   (divided_pulse_select_reg),
        .div_pulse  (div_pulse)
    );

    // source terms, each but the soft pulses behind its own enable; the comparator is taken as
    // already synchronised upstream, a raw analog edge here could glitch the latch
    assign set_soft    = soft_set_pulse_reg;
    assign set_clock   = clock_set_enable_reg & div_pulse;
    assign set_pin     = pin_set_enable_reg & pin_level_reg;
    assign set_cmp     = comparator_set_enable_reg & comparator_result;
    assign reset_soft  = soft_reset_pulse_reg;
    assign reset_clock = clock_reset_enable_reg & div_pulse;
    assign reset_pin   = pin_reset_enable_reg & pin_level_reg;
    assign reset_cmp   = comparator_reset_enable_reg & comparator_result;

    // effective inputs: plain OR of the enabled terms, dominance left to the latch
    assign latch_set   = set_soft | set_clock | set_pin | set_cmp;
    assign latch_reset = reset_soft | reset_clock | reset_pin | reset_cmp;

    // level-sensitive latch, reset first; inputs come from flops so no glitches
    // it deliberately has no reset term, so it wakes unknown
    always_latch
    begin
        if (latch_reset)
            latch_q <= 1'b0;
        else if (latch_set)
            latch_q <= 1'b1;
    end

    // pin outputs: each enable is gated by latch_enable_reg, not by the other; both may drive at once
    assign true_drive             = latch_enable_reg & true_output_enable_reg;
    assign complement_drive       = latch_enable_reg
                                  & complement_output_enable_reg;
    assign true_output_pin        = true_drive & latch_q;
    assign true_output_oe_b       = ~true_drive;
    assign complement_output_pin  = complement_drive & ~latch_q;
    assign complement_output_oe_b = ~complement_drive;

endmodule : srl_latch_top

// ===== hw/srl_pkg.sv
// Purpose: shared types of the set/reset latch unit
// Assumes: constants live in srl_regs.svh
// Notes:   one-hot state codes written out
package srl_pkg;

    // bus slave handshake states
    typedef enum logic [1:0] {
        SRL_BUS_IDLE = 2'b01,
        SRL_BUS_ACK  = 2'b10
    } srl_bus_state_t;

endpackage : srl_pkg

// ===== hw/srl_pulse_div.sv
// Purpose: free-running divider giving a one-cycle pulse every 4..512 clocks
// Assumes: single clock, synchronous use of the pulse
// Notes:   changing the code mid-period only shifts the next pulse
`timescale 1ns/10ps
`include "srl_regs.svh"

module srl_pulse_div #(
    parameter int SEL_W = `SRL_DIV_SEL_W,
    parameter int CNT_W = `SRL_DIV_CNT_W
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_sync_b,
    input  wire logic [SEL_W-1:0] div_code,
    output logic                  div_pulse
);

    // counter must reach the longest period exactly, and the shift amount
    // is four bits wide, which caps the code width at three
    if (SEL_W > 3 || CNT_W != 2 + (1 << SEL_W) - 1)
    begin : g_bad_width
        $error("srl_pulse_div: CNT_W does not fit SEL_W");
    end

    logic [CNT_W-1:0] cnt_reg;
    logic             pulse_reg;
    logic [3:0]       shift_amt;
    logic [CNT_W-1:0] low_mask;
    logic             period_end;

    // period is 2**(code+2): pulse when the low code+2 bits are all ones
    assign shift_amt  = {1'b0, div_code} + `SRL_DIV_MIN_LOG2;
    assign low_mask   = ~({CNT_W{1'b1}} << shift_amt);
    assign period_end = (cnt_reg & low_mask) == low_mask;

    // free-running, software never stops or restarts it
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            cnt_reg   <= '0;
            pulse_reg <= 1'b0;
        end
        else
        begin
            cnt_reg   <= cnt_reg + 1'b1;
            pulse_reg <= period_end;
        end
    end

    assign div_pulse = pulse_reg;

endmodule : srl_pulse_div

// ===== hw/srl_regs.svh
// Purpose: register offsets, field positions, reset values and divider counts
// Assumes: included by its bare name wherever the latch map is needed
// Notes:   word indices on a 32-bit slave; byte address is four times the index
`ifndef SRL_REGS_SVH
`define SRL_REGS_SVH

// register word indices
`define SRL_IDX_PRIMARY        2'h0
`define SRL_IDX_SOURCE         2'h1
`define SRL_IDX_STATUS         2'h2

// latch_control_primary fields
`define SRL_PRI_LATCH_ENABLE   7
`define SRL_PRI_DIV_SEL_HI     6
`define SRL_PRI_DIV_SEL_LO     4
`define SRL_PRI_TRUE_OE        3
`define SRL_PRI_COMP_OE        2
`define SRL_PRI_SOFT_SET       1
`define SRL_PRI_SOFT_RESET     0

// latch_source_select fields
`define SRL_SRC_PIN_SET        7
`define SRL_SRC_CLK_SET        6
`define SRL_SRC_RSVD_HI        5
`define SRL_SRC_CMP_SET        4
`define SRL_SRC_PIN_RESET      3
`define SRL_SRC_CLK_RESET      2
`define SRL_SRC_RSVD_LO        1
`define SRL_SRC_CMP_RESET      0

// status fields
`define SRL_STA_LATCH_Q        0
`define SRL_STA_PIN_LEVEL      1
`define SRL_STA_CMP_LEVEL      2

// reset values
`define SRL_PRIMARY_RESET      8'h00
`define SRL_SOURCE_RESET       8'h00

// divider: code 0 gives a period of 2**2 clocks, each code doubles it
`define SRL_DIV_MIN_LOG2       4'h2
`define SRL_DIV_SEL_W          3
`define SRL_DIV_CNT_W          9

`endif
